// File: logic/cbm_map.svh
// Register offsets, field positions and sizes of the buffer cache manager
// What this block does
// - Hardware tracks up to 64K blocks per command
// - Drives 16-bit DRAM, 512K bytes, FPM or EDO
// - Blocks are 2.5K or 3K bytes each
// - Blocks laid out linearly, block maps to address
// - Burst of up to 256 blocks, no firmware
// - Each DRQ packet carries largest allowed count
// - Auto cache starts while cached blocks nonzero
// - Auto completion posted when enable bit set
// - Done flag set; interrupt only if masked in
// - Second segment chained after first completes
// - Block numbers run zero to bottom register
// - Host and disc pointers step per block
// - Pointers wrap to zero past bottom block; 8-bit disc pointer past 255 at most
// - Mode bit picks physical or block addressing
// - Block mode: block number plus 16-bit offset
// - Start bits launch one read or write
// - Busy held while access pending; firmware waits
// - Space past bottom block is system area
// - System area transfers ignore block boundaries
// - Byte transfer done only after full length
`ifndef CBM_MAP_SVH
`define CBM_MAP_SVH
// ==================================================
// Register offsets
`define CBM_A_TSEQ 8'h0F
`define CBM_A_STAT 8'h10
`define CBM_A_MASK 8'h12
`define CBM_A_VCNT_L 8'h14
`define CBM_A_VCNT_H 8'h15
`define CBM_A_TOT_L 8'h16
`define CBM_A_TOT_H 8'h17
`define CBM_A_BLEN_L 8'h18
`define CBM_A_BLEN_H 8'h19
`define CBM_A_HPTR_L 8'h1A
`define CBM_A_HPTR_H 8'h1B
`define CBM_A_S1OFF_L 8'h1C
`define CBM_A_S1OFF_H 8'h1D
`define CBM_A_S1LEN_L 8'h1E
`define CBM_A_S1LEN_H 8'h1F
`define CBM_A_S2OFF_L 8'h20
`define CBM_A_S2OFF_H 8'h21
`define CBM_A_S2LEN_L 8'h22
`define CBM_A_S2LEN_H 8'h23
`define CBM_A_ADR_L 8'h24
`define CBM_A_ADR_M 8'h25
`define CBM_A_ADR_H 8'h26
`define CBM_A_DATA 8'h28
`define CBM_A_ACTL 8'h29
`define CBM_A_BOT_L 8'h2C
`define CBM_A_BOT_H 8'h2D
`define CBM_A_DPTR 8'h38
// ==================================================
// Field positions
`define CBM_B_AUTO 7
`define CBM_B_POST 6
`define CBM_B_SYS 0
`define CBM_B_DONE 7
`define CBM_B_RD 0
`define CBM_B_WR 1
`define CBM_B_MODE 2
`define CBM_B_BUSY 7
// ==================================================
// Sizes and limits
`define CBM_BURST_MAX 9'h100
`define CBM_PKT_MAX 20'h0FFFE
`endif

// File: logic/cbm_pkg.sv
// Types shared by the buffer cache manager
package cbm_pkg;
  // Host transfer engine states
  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_DONE} cbm_state_t;
  // Current owner of the DRAM port
  typedef enum logic [1:0] {OWN_NONE, OWN_CPU, OWN_HOST} cbm_owner_t;
endpackage

// File: logic/cbm_top.sv
// Buffer cache manager: host transfer engine, CPU DRAM access, FIFO
`timescale 1ns/100ps
`include "cbm_map.svh"

// ==================================================
// Output FIFO between DRAM reads and the host port
module cbm_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Synchronised reset
  input wire logic ce_in, // Clock enable
  input wire logic in_valid_in, // Write request
  output logic in_ready_out, // Room left
  input wire logic [W-1:0] in_data_in, // Write data
  output logic out_valid_out, // Data present
  input wire logic out_ready_in, // Reader takes word
  output logic [W-1:0] out_data_out // Head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D]; // Storage
  logic [AW-1:0] wr_q; // Write index
  logic [AW-1:0] rd_q; // Read index
  logic [AW:0] cnt_q; // Fill level
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (cnt_q != (AW+1)'(D));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];

  // Storage needs no reset; the count guards it
  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce_in) begin
      if (push) wr_q <= AW'(wr_q + 1'b1);
      if (pop) rd_q <= AW'(rd_q + 1'b1);
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end
endmodule

// ==================================================
// Top level
module cbm_top import cbm_pkg::*; (
  input wire logic core_clk_in, // 100 MHz clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic ce_in, // Clock enable
  input wire logic block_size_3k_in, // 1: 3K blocks, 0: 2.5K
  input wire logic edo_mode_in, // 1: EDO DRAM, 0: fast page
  input wire logic [7:0] reg_addr_in, // Register offset
  input wire logic reg_wr_in, // Register write strobe
  input wire logic reg_rd_in, // Register read strobe
  input wire logic [7:0] reg_wdata_in, // Write data
  output logic [7:0] reg_rdata_out, // Read data, next cycle
  input wire logic disc_block_done_in, // One block stored from disc
  output logic dram_req_out, // DRAM access request
  output logic dram_we_out, // 1: write
  output logic [18:0] dram_addr_out, // Byte address
  output logic [1:0] dram_be_out, // Byte lanes
  output logic [15:0] dram_wdata_out, // Write data
  input wire logic dram_ack_in, // Access done
  input wire logic [15:0] dram_rdata_in, // Read data with ack
  output logic dram_edo_out, // DRAM type to the timing logic
  output logic host_valid_out, // Host word available
  output logic [15:0] host_data_out, // Host word
  input wire logic host_ready_in, // Host takes word
  output logic packet_start_out, // New DRQ packet pulse
  output logic [15:0] packet_bytes_out, // Packet byte count
  output logic completion_post_out, // Completion status pulse
  output logic cpu_irq_out // Microprocessor interrupt
);
  // ==================================================
  // Reset synchroniser
  logic rs1_q; // First stage
  logic rst_n; // Released copy
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // ==================================================
  // Linear block to byte address; 2.5K = 2K+512, 3K = 2K+1K
  function automatic logic [18:0] block_base(input logic [15:0] blk,
                                             input logic big);
    logic [18:0] b;
    b = {blk[7:0], 11'h000};
    block_base = big ? 19'(b + {blk[8:0], 10'h000})
                     : 19'(b + {blk[9:0], 9'h000});
  endfunction

  // ==================================================
  // Registers
  logic [7:0] tseq_q; // Transfer sequence command
  logic done_q; // Transfer finished flag
  logic [7:0] mask_q; // Interrupt mask
  logic [15:0] vcnt_q; // Cached blocks ready
  logic [15:0] tot_q; // Overall blocks remaining
  logic [15:0] blen_q; // Burst block length
  logic [15:0] hptr_q; // Host block pointer
  logic [15:0] s1off_q, s1len_q, s2off_q, s2len_q; // Segments
  logic [23:0] cadr_q; // CPU DRAM address
  logic [7:0] cdat_q; // CPU data port
  logic mode_q; // 1: block addressing mode
  logic cpend_q; // CPU access pending
  logic cwr_q; // Pending access is a write
  logic [15:0] bot_q; // Last data block
  logic [7:0] dptr_q; // Disc block pointer
  // Engine state
  cbm_state_t st_q;
  cbm_owner_t own_q; // DRAM owner while req is up
  logic seg2_q; // Working on second segment
  logic sys_q; // System area byte transfer
  logic [18:0] xadr_q; // Next host read address
  logic [15:0] sleft_q; // Bytes left in segment
  logic [8:0] bblk_q; // Blocks left in burst
  logic [19:0] bbytes_q; // Bytes left in burst
  logic [15:0] pleft_q; // Bytes left in DRQ packet
  logic post_q; // Completion pulse

  // ==================================================
  // Decode
  wire wr = reg_wr_in;
  wire [7:0] a = reg_addr_in;
  wire [15:0] hptr_inc = 16'(hptr_q + 1'b1);
  wire [15:0] bot_p1 = 16'(bot_q + 1'b1);
  wire [15:0] hptr_nx = (hptr_inc == bot_p1) ? 16'h0000 : hptr_inc;
  wire [7:0] dptr_inc = 8'(dptr_q + 1'b1);
  wire [7:0] dptr_nx = ({8'h00, dptr_inc} == bot_p1) ? 8'h00 : dptr_inc;
  wire [18:0] sys_base = block_base(bot_p1, block_size_3k_in);
  wire [18:0] cpu_adr = mode_q
      ? 19'(block_base({8'h00, cadr_q[23:16]}, block_size_3k_in)
            + cadr_q[15:0])
      : cadr_q[18:0];
  wire [16:0] blk_bytes = 17'(s1len_q + s2len_q);
  wire [8:0] burst_req = (blen_q == 16'h0000 || blen_q > 16'h0100)
      ? `CBM_BURST_MAX : blen_q[8:0];
  wire [8:0] burst_v = (vcnt_q < 16'(burst_req)) ? vcnt_q[8:0] : burst_req;
  wire [8:0] burst_n = (tot_q < 16'(burst_v)) ? tot_q[8:0] : burst_v;
  wire sys_go = tseq_q[`CBM_B_SYS];
  wire auto_go = tseq_q[`CBM_B_AUTO] && vcnt_q != 0 && tot_q != 0;
  wire fifo_rdy; // FIFO has room
  wire host_want = st_q == ST_XFER && pleft_q != 0 && fifo_rdy;
  wire idle_port = own_q == OWN_NONE;
  wire cpu_take = idle_port && cpend_q; // CPU wins a free port
  wire host_take = idle_port && !cpend_q && host_want;
  wire word_done = dram_ack_in && own_q == OWN_HOST;
  wire cpu_done = dram_ack_in && own_q == OWN_CPU;
  wire [15:0] step = (sleft_q >= 16'h0002) ? 16'h0002 : sleft_q;
  wire seg_end = word_done && sleft_q == step;
  wire chain = seg_end && !sys_q && !seg2_q && s2len_q != 0;
  wire blk_done = seg_end && !sys_q && !chain;
  wire last_blk = blk_done && (tot_q == 16'h0001 || bblk_q == 9'h001);
  wire fin = (seg_end && sys_q) || (blk_done && tot_q == 16'h0001);
  wire pkt_go = st_q == ST_XFER && pleft_q == 0 && bbytes_q != 0;
  wire [19:0] pkt_n = (bbytes_q > `CBM_PKT_MAX) ? `CBM_PKT_MAX : bbytes_q;

  // ==================================================
  // Configuration registers written by firmware only; dram_edo_out follows edo_mode_in
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= 8'h00;
      blen_q <= 16'h0000;
      s1off_q <= 16'h0000;
      s1len_q <= 16'h0000;
      s2off_q <= 16'h0000;
      s2len_q <= 16'h0000;
      cadr_q <= 24'h000000;
      bot_q <= 16'h0000;
      mode_q <= 1'b0;
      dram_edo_out <= 1'b0;
    end else if (ce_in) begin
      dram_edo_out <= edo_mode_in;
      if (wr) begin
        case (a)
          `CBM_A_MASK: mask_q <= reg_wdata_in;
          `CBM_A_BLEN_L: blen_q[7:0] <= reg_wdata_in;
          `CBM_A_BLEN_H: blen_q[15:8] <= reg_wdata_in;
          `CBM_A_S1OFF_L: s1off_q[7:0] <= reg_wdata_in;
          `CBM_A_S1OFF_H: s1off_q[15:8] <= reg_wdata_in;
          `CBM_A_S1LEN_L: s1len_q[7:0] <= reg_wdata_in;
          `CBM_A_S1LEN_H: s1len_q[15:8] <= reg_wdata_in;
          `CBM_A_S2OFF_L: s2off_q[7:0] <= reg_wdata_in;
          `CBM_A_S2OFF_H: s2off_q[15:8] <= reg_wdata_in;
          `CBM_A_S2LEN_L: s2len_q[7:0] <= reg_wdata_in;
          `CBM_A_S2LEN_H: s2len_q[15:8] <= reg_wdata_in;
          `CBM_A_ADR_L: cadr_q[7:0] <= reg_wdata_in;
          `CBM_A_ADR_M: cadr_q[15:8] <= reg_wdata_in;
          `CBM_A_ADR_H: cadr_q[23:16] <= reg_wdata_in;
          `CBM_A_BOT_L: bot_q[7:0] <= reg_wdata_in;
          `CBM_A_BOT_H: bot_q[15:8] <= reg_wdata_in;
          `CBM_A_ACTL: mode_q <= reg_wdata_in[`CBM_B_MODE];
          default: ;
        endcase
      end
    end
  end

  // ==================================================
  // Counters and pointers shared with hardware; firmware write wins, except on the done flag
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tseq_q <= 8'h00;
      vcnt_q <= 16'h0000;
      tot_q <= 16'h0000;
      hptr_q <= 16'h0000;
      dptr_q <= 8'h00;
      done_q <= 1'b0;
    end else if (ce_in) begin
      // Start bit for system transfers clears itself once taken
      if (wr && a == `CBM_A_TSEQ) tseq_q <= reg_wdata_in;
      else if (st_q == ST_IDLE && sys_go) tseq_q[`CBM_B_SYS] <= 1'b0;
      // Disc adds a block, host delivery removes one
      if (wr && a == `CBM_A_VCNT_L) vcnt_q[7:0] <= reg_wdata_in;
      else if (wr && a == `CBM_A_VCNT_H) vcnt_q[15:8] <= reg_wdata_in;
      else vcnt_q <= 16'(vcnt_q + disc_block_done_in - blk_done);
      if (wr && a == `CBM_A_TOT_L) tot_q[7:0] <= reg_wdata_in;
      else if (wr && a == `CBM_A_TOT_H) tot_q[15:8] <= reg_wdata_in;
      else if (blk_done) tot_q <= 16'(tot_q - 1'b1);
      if (wr && a == `CBM_A_HPTR_L) hptr_q[7:0] <= reg_wdata_in;
      else if (wr && a == `CBM_A_HPTR_H) hptr_q[15:8] <= reg_wdata_in;
      else if (blk_done) hptr_q <= hptr_nx;
      if (wr && a == `CBM_A_DPTR) dptr_q <= reg_wdata_in;
      else if (disc_block_done_in) dptr_q <= dptr_nx;
      // Set wins over write-one-to-clear
      if (fin) done_q <= 1'b1;
      else if (wr && a == `CBM_A_STAT && reg_wdata_in[`CBM_B_DONE])
        done_q <= 1'b0;
    end
  end

  // ==================================================
  // CPU DRAM access: one byte cycle per start bit
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cpend_q <= 1'b0;
      cwr_q <= 1'b0;
      cdat_q <= 8'h00;
    end else if (ce_in) begin
      if (cpu_done) begin
        cpend_q <= 1'b0;
        if (!cwr_q) cdat_q <= cpu_adr[0] ? dram_rdata_in[15:8]
                                         : dram_rdata_in[7:0];
      end else if (wr && a == `CBM_A_DATA && !cpend_q) begin
        cdat_q <= reg_wdata_in; // Ignored while busy
      end
      if (wr && a == `CBM_A_ACTL && !cpend_q &&
          (reg_wdata_in[`CBM_B_RD] || reg_wdata_in[`CBM_B_WR])) begin
        cpend_q <= 1'b1;
        cwr_q <= reg_wdata_in[`CBM_B_WR];
      end
    end
  end

  // ==================================================
  // DRAM port: request held until ack
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      own_q <= OWN_NONE;
      dram_req_out <= 1'b0;
      dram_we_out <= 1'b0;
      dram_addr_out <= 19'h00000;
      dram_be_out <= 2'h0;
      dram_wdata_out <= 16'h0000;
    end else if (ce_in) begin
      if (dram_ack_in) begin
        own_q <= OWN_NONE;
        dram_req_out <= 1'b0;
      end else if (cpu_take) begin
        own_q <= OWN_CPU;
        dram_req_out <= 1'b1;
        dram_we_out <= cwr_q;
        dram_addr_out <= cpu_adr;
        dram_be_out <= cpu_adr[0] ? 2'h2 : 2'h1;
        dram_wdata_out <= {cdat_q, cdat_q};
      end else if (host_take) begin
        own_q <= OWN_HOST;
        dram_req_out <= 1'b1;
        dram_we_out <= 1'b0;
        dram_addr_out <= {xadr_q[18:1], 1'b0};
        dram_be_out <= 2'h3;
      end
    end
  end

  // ==================================================
  // Host transfer engine
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      seg2_q <= 1'b0;
      sys_q <= 1'b0;
      xadr_q <= 19'h00000;
      sleft_q <= 16'h0000;
      bblk_q <= 9'h000;
      bbytes_q <= 20'h00000;
    end else if (ce_in) begin
      case (st_q)
        ST_IDLE: begin
          seg2_q <= 1'b0;
          if (sys_go) begin
            sys_q <= 1'b1;
            xadr_q <= 19'(sys_base + s1off_q);
            sleft_q <= s1len_q;
            bbytes_q <= {4'h0, s1len_q};
            st_q <= ST_XFER;
          end else if (auto_go) begin
            sys_q <= 1'b0;
            xadr_q <= 19'(block_base(hptr_q, block_size_3k_in) + s1off_q);
            sleft_q <= s1len_q;
            bblk_q <= burst_n;
            bbytes_q <= 20'(burst_n * blk_bytes);
            st_q <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (word_done) begin
            xadr_q <= 19'(xadr_q + step);
            sleft_q <= 16'(sleft_q - step);
            bbytes_q <= 20'(bbytes_q - step);
          end
          if (chain) begin
            seg2_q <= 1'b1;
            xadr_q <= 19'(block_base(hptr_q, block_size_3k_in) + s2off_q);
            sleft_q <= s2len_q;
          end else if (fin) begin
            st_q <= ST_DONE;
          end else if (last_blk) begin
            st_q <= ST_IDLE; // Burst over, re-check the cache
          end else if (blk_done) begin
            seg2_q <= 1'b0;
            bblk_q <= 9'(bblk_q - 1'b1);
            xadr_q <= 19'(block_base(hptr_nx, block_size_3k_in) + s1off_q);
            sleft_q <= s1len_q;
          end
        end
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ==================================================
  // DRQ packets, completion and register readback
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pleft_q <= 16'h0000;
      packet_start_out <= 1'b0;
      packet_bytes_out <= 16'h0000;
      post_q <= 1'b0;
      reg_rdata_out <= 8'h00;
    end else if (ce_in) begin
      packet_start_out <= pkt_go;
      if (pkt_go) begin
        pleft_q <= pkt_n[15:0];
        packet_bytes_out <= pkt_n[15:0];
      end else if (word_done) begin
        pleft_q <= (pleft_q > step) ? 16'(pleft_q - step) : 16'h0000;
      end
      post_q <= fin && tseq_q[`CBM_B_POST];
      if (reg_rd_in) begin
        case (a)
          `CBM_A_TSEQ: reg_rdata_out <= tseq_q;
          `CBM_A_STAT: reg_rdata_out <= {done_q, 7'h00};
          `CBM_A_MASK: reg_rdata_out <= mask_q;
          `CBM_A_VCNT_L: reg_rdata_out <= vcnt_q[7:0];
          `CBM_A_VCNT_H: reg_rdata_out <= vcnt_q[15:8];
          `CBM_A_TOT_L: reg_rdata_out <= tot_q[7:0];
          `CBM_A_TOT_H: reg_rdata_out <= tot_q[15:8];
          `CBM_A_BLEN_L: reg_rdata_out <= blen_q[7:0];
          `CBM_A_BLEN_H: reg_rdata_out <= blen_q[15:8];
          `CBM_A_HPTR_L: reg_rdata_out <= hptr_q[7:0];
          `CBM_A_HPTR_H: reg_rdata_out <= hptr_q[15:8];
          `CBM_A_S1OFF_L: reg_rdata_out <= s1off_q[7:0];
          `CBM_A_S1OFF_H: reg_rdata_out <= s1off_q[15:8];
          `CBM_A_S1LEN_L: reg_rdata_out <= s1len_q[7:0];
          `CBM_A_S1LEN_H: reg_rdata_out <= s1len_q[15:8];
          `CBM_A_S2OFF_L: reg_rdata_out <= s2off_q[7:0];
          `CBM_A_S2OFF_H: reg_rdata_out <= s2off_q[15:8];
          `CBM_A_S2LEN_L: reg_rdata_out <= s2len_q[7:0];
          `CBM_A_S2LEN_H: reg_rdata_out <= s2len_q[15:8];
          `CBM_A_ADR_L: reg_rdata_out <= cadr_q[7:0];
          `CBM_A_ADR_M: reg_rdata_out <= cadr_q[15:8];
          `CBM_A_ADR_H: reg_rdata_out <= cadr_q[23:16];
          `CBM_A_DATA: reg_rdata_out <= cdat_q;
          `CBM_A_ACTL: reg_rdata_out <= {cpend_q, 4'h0, mode_q, 2'h0};
          `CBM_A_BOT_L: reg_rdata_out <= bot_q[7:0];
          `CBM_A_BOT_H: reg_rdata_out <= bot_q[15:8];
          `CBM_A_DPTR: reg_rdata_out <= dptr_q;
          default: reg_rdata_out <= 8'h00; // Unmapped reads zero
        endcase
      end
    end
  end
  assign completion_post_out = post_q;
  assign cpu_irq_out = done_q && mask_q[`CBM_B_DONE];

  // ==================================================
  // Read words queue here so a slow host stalls DRAM reads
  cbm_fifo #(.W(16), .D(16)) u_fifo (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .in_valid_in(word_done),
    .in_ready_out(fifo_rdy),
    .in_data_in(dram_rdata_in),
    .out_valid_out(host_valid_out),
    .out_ready_in(host_ready_in),
    .out_data_out(host_data_out)
  );

  // ==================================================
  // Checks
  default clocking cb @(posedge core_clk_in iff ce_in); endclocking
  default disable iff (!rst_n);
  sequence s_launch;
    st_q == ST_IDLE ##1 (st_q == ST_XFER && !sys_q);
  endsequence
  a_done_sets_flag: assert property (fin |=> done_q)
    else $error("done flag not set");
  a_flag_from_fin: assert property ($rose(done_q) |-> $past(fin))
    else $error("done flag set without completion");
  a_post_needs_en: assert property (post_q |-> $past(tseq_q[`CBM_B_POST]))
    else $error("completion posted while disabled");
  a_busy_holds: assert property (cpend_q && !cpu_done |=> cpend_q)
    else $error("busy dropped early");
  a_ptr_wrap: assert property (blk_done && !wr && hptr_inc == bot_p1
                               |=> hptr_q == 16'h0000)
    else $error("host pointer did not wrap");
  a_ptr_step: assert property (blk_done && !wr && hptr_inc != bot_p1
                               |=> hptr_q == $past(hptr_q) + 16'h0001)
    else $error("host pointer did not step");
  a_pkt_limit: assert property (packet_start_out |->
      packet_bytes_out != 0 && packet_bytes_out <= 16'hFFFE)
    else $error("packet size out of range");
  a_total_dec: assert property (blk_done && !wr
                                |=> tot_q == $past(tot_q) - 16'h0001)
    else $error("total count not decremented");
  a_launch_cache: assert property (s_launch |-> $past(vcnt_q) != 0)
    else $error("started with empty cache");
endmodule

// File: tb/cbm_dram_model.sv
// Behavioural buffer DRAM answering the manager's request port
`timescale 1ns/100ps
module cbm_dram_model (
  input wire logic clk_in, // Clock
  input wire logic req_in, // Access request
  input wire logic we_in, // 1: write
  input wire logic [18:0] addr_in, // Byte address
  input wire logic [1:0] be_in, // Byte lanes
  input wire logic [15:0] wdata_in, // Write data
  input wire logic [3:0] lat_in, // Wait cycles before ack
  output logic ack_out, // One-cycle done pulse
  output logic [15:0] rdata_out // Read data with ack
);
  logic [15:0] mem_q [262144]; // Whole store as 16-bit words
  logic [3:0] cnt_q = 4'h0; // Wait counter
  logic [15:0] w; // Word being accessed
  initial ack_out = 1'b0;
  initial rdata_out = 16'h0000;
  // Every word starts as the low 16 bits of its index so reads are predictable
  initial begin
    for (int i = 0; i < 262144; i++) mem_q[i] = 16'(i);
  end
  // ==================================================
  // Answer after lat_in cycles; data lines toggle when not valid
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    cnt_q <= (req_in && !ack_out) ? cnt_q + 4'h1 : 4'h0;
    if (req_in && !ack_out && cnt_q >= lat_in) begin
      w = mem_q[addr_in[18:1]];
      if (we_in && be_in[0]) w[7:0] = wdata_in[7:0];
      if (we_in && be_in[1]) w[15:8] = wdata_in[15:8];
      if (we_in) mem_q[addr_in[18:1]] = w;
      ack_out <= 1'b1;
      rdata_out <= w;
      cnt_q <= 4'h0;
    end
  end
endmodule

// File: tb/tb.sv
// Self-checking bench for the buffer cache manager
`timescale 1ns/100ps
module tb;
  logic core_clk_in = 1'b0, arst_n_in = 1'b0, ce_in = 1'b1;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, disc_block_done_in = 1'b0;
  logic block_size_3k_in = 1'b0, edo_mode_in = 1'b0, host_ready_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic dram_req_out, dram_we_out, dram_ack_in, dram_edo_out;
  logic host_valid_out, packet_start_out, completion_post_out, cpu_irq_out;
  logic [18:0] dram_addr_out;
  logic [1:0] dram_be_out;
  logic [15:0] dram_wdata_out, dram_rdata_in, host_data_out, packet_bytes_out;
  logic [3:0] lat = 4'h1; // DRAM answer delay
  logic [15:0] words [$]; // Host words received
  int num_errors = 0, total_checks = 0, cycles = 0, posts = 0;
  // Setup of a two-block cached read, block 3 then wrap to 0
  logic [15:0] cfg [20] = '{16'h2C03, 16'h2D00, 16'h1A03, 16'h1B00,
    16'h1401, 16'h1500, 16'h1602, 16'h1700, 16'h1800, 16'h1900,
    16'h1C00, 16'h1D00, 16'h1E28, 16'h1F00, 16'h2008, 16'h2100,
    16'h2202, 16'h2300, 16'h1280, 16'h0FC0};
  cbm_top dut (.core_clk_in, .arst_n_in, .ce_in, .block_size_3k_in,
    .edo_mode_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
    .reg_rdata_out, .disc_block_done_in, .dram_req_out, .dram_we_out,
    .dram_addr_out, .dram_be_out, .dram_wdata_out, .dram_ack_in,
    .dram_rdata_in, .dram_edo_out, .host_valid_out, .host_data_out,
    .host_ready_in, .packet_start_out, .packet_bytes_out,
    .completion_post_out, .cpu_irq_out);
  cbm_dram_model mem (.clk_in(core_clk_in), .req_in(dram_req_out),
    .we_in(dram_we_out), .addr_in(dram_addr_out), .be_in(dram_be_out),
    .wdata_in(dram_wdata_out), .lat_in(lat), .ack_out(dram_ack_in),
    .rdata_out(dram_rdata_in));
  always #5 core_clk_in = ~core_clk_in;
  // ==================================================
  // Checking and run control
  task automatic chk(input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task conclude;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Host sink, packet and completion monitor, hang guard
  always @(posedge core_clk_in) begin
    if (host_valid_out && host_ready_in) words.push_back(host_data_out);
    if (completion_post_out) posts++;
    if (packet_start_out) chk(packet_bytes_out, 16'h002A);
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude;
    end
  end
  // ==================================================
  // Register access: strobe for one taken edge
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdv(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge core_clk_in);
    v = reg_rdata_out;
  endtask
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] v;
    rdv(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  // Poll busy under a bound, since firmware may not touch data before
  task automatic idle;
    logic [7:0] v = 8'hFF;
    for (int n = 0; n < 50 && v[7] !== 1'b0; n++) rdv(8'h29, v);
    chk({15'h0000, v[7]}, 16'h0000);
  endtask
  task automatic waitw(input int n);
    for (int c = 0; c < 3000 && words.size() < n; c++) @(posedge core_clk_in);
    chk(16'(words.size()), 16'(n));
  endtask
  // ==================================================
  // Main sequence
  initial begin
    int i;
    repeat (12) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    wr(8'h1A, 8'h5A);
    rd(8'h1A, 8'h5A);
    rd(8'h30, 8'h00); // Unmapped offset reads zero
    // Physical write of byte 0A05h, then block 1 offset 5 read
    wr(8'h24, 8'h05); wr(8'h25, 8'h0A); wr(8'h26, 8'h00);
    wr(8'h28, 8'hC3); wr(8'h29, 8'h02); idle();
    wr(8'h24, 8'h05); wr(8'h25, 8'h00); wr(8'h26, 8'h01);
    wr(8'h29, 8'h05); idle();
    rd(8'h28, 8'hC3);
    // Slow DRAM and stalled host so the FIFO holds 11 of 16 words
    lat <= 4'h4;
    host_ready_in <= 1'b0;
    foreach (cfg[k]) wr(cfg[k][15:8], cfg[k][7:0]);
    repeat (80) @(posedge core_clk_in);
    host_ready_in <= 1'b1;
    waitw(21);
    repeat (10) @(posedge core_clk_in);
    rd(8'h14, 8'h00);
    rd(8'h16, 8'h01);
    rd(8'h10, 8'h00);
    rd(8'h1A, 8'h00);
    @(posedge core_clk_in) disc_block_done_in <= 1'b1;
    @(posedge core_clk_in) disc_block_done_in <= 1'b0;
    waitw(42);
    repeat (10) @(posedge core_clk_in);
    rd(8'h10, 8'h80);
    chk({15'h0000, cpu_irq_out}, 16'h0001);
    chk(16'(posts), 16'h0001);
    rd(8'h1A, 8'h01);
    rd(8'h16, 8'h00);
    for (int k = 0; k < 42; k++) begin
      i = k % 21;
      chk(words[k], (k < 21 ? 16'h0F00 : 16'h0000) + 16'(i < 20 ? i : 4));
    end
    // System area read, 3K blocks: starts at base of block 4
    block_size_3k_in <= 1'b1;
    edo_mode_in <= 1'b1;
    wr(8'h10, 8'h80);
    rd(8'h10, 8'h00);
    wr(8'h1E, 8'h2A);
    wr(8'h0F, 8'h41);
    waitw(63);
    repeat (10) @(posedge core_clk_in);
    rd(8'h10, 8'h80);
    rd(8'h0F, 8'h40);
    chk(16'(posts), 16'h0002);
    chk({15'h0000, dram_edo_out}, 16'h0001);
    for (int k = 42; k < 63; k++) begin
      chk(words[k], 16'h1800 + 16'(k - 42));
    end
    wr(8'h12, 8'h00);
    @(posedge core_clk_in) chk({15'h0000, cpu_irq_out}, 16'h0000);
    conclude;
  end
endmodule
